// *** pkg/tws_consts.svh ***
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH
`define TWS_FRAME_BITS 8
`define TWS_BUF_DEPTH 32
`define TWS_DIV_W 4
`define TWS_GAP_W 8
`define TWS_GAP_UNIT 4
`endif

// *** pkg/tws_pkg.sv ***
`default_nettype none
package tws_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_LOAD = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_GAP = 4'b1000
   } tws_state_t;
   typedef struct packed {
      logic port_enable_bit;
      logic auto_transfer_enable;
      logic continuous_transfer_bit;
      logic receive_enable_bit;
      logic transmit_enable_bit;
      logic bit_order_select;
   } tws_mode_t;
   typedef struct packed {
      logic en;
      logic [4:0] addr;
      logic [7:0] data;
   } tws_ram_req_t;
endpackage
`default_nettype wire

// *** rtl/tws_buf_ram.sv ***
`timescale 1ns/10ps
`default_nettype none
module tws_buf_ram
   import tws_pkg::*;
#(
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic clk,
   input wire tws_ram_req_t wr_a,
   input wire tws_ram_req_t wr_b,
   input wire logic [AW-1:0] rd_addr_a,
   output logic [7:0] rd_data_a,
   input wire logic [AW-1:0] rd_addr_b,
   output logic [7:0] rd_data_b
);
   logic [7:0] mem [DEPTH];
   initial
   begin
      if (DEPTH != (1 << AW)) $error("depth must match address width");
   end
   // port b (engine) wins on a same-cycle write collision
   always_ff @(posedge clk)
   begin
      if (wr_b.en)
         mem[wr_b.addr[AW-1:0]] <= wr_b.data;
      else if (wr_a.en)
         mem[wr_a.addr[AW-1:0]] <= wr_a.data;
   end
   always_ff @(posedge clk)
   begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
   end
endmodule
`default_nettype wire

// *** rtl/tws_clk_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
module tws_clk_gen #(
   parameter int DW = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic [DW-1:0] div_sel,
   output logic fall_p,
   output logic rise_p,
   output logic sck_r
);
   logic [DW-1:0] cnt_r;
   logic tick;
   initial
   begin
      if (DW < 1 || DW > 16) $error("divisor width out of range");
   end
   assign tick = (cnt_r == div_sel);
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cnt_r <= '0;
      else if (!run || tick)
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end
   // serial clock idles high and toggles every div_sel+1 cycles
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         sck_r <= 1'b1;
      else if (!run)
         sck_r <= 1'b1;
      else if (tick)
         sck_r <= ~sck_r;
   end
   assign fall_p = run && tick && sck_r;
   assign rise_p = run && tick && !sck_r;
endmodule
`default_nettype wire

// *** rtl/tws_serial_port.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tws_consts.svh"
module tws_serial_port
   import tws_pkg::*;
#(
   parameter int DEPTH = `TWS_BUF_DEPTH,
   parameter int DIV_W = `TWS_DIV_W
) (
   input wire logic clk,
   input wire logic rstn,
   input wire tws_mode_t serial_mode_control,
   input wire logic [DIV_W-1:0] clock_divisor_select,
   input wire logic [4:0] transfer_end_point,
   input wire logic [`TWS_GAP_W-1:0] transfer_interval_setting,
   input wire logic auto_start_trigger,
   input wire logic auto_stop_trigger,
   input wire logic shift_wr,
   input wire logic [7:0] shift_wdata,
   output logic [7:0] shift_rdata,
   input wire tws_ram_req_t cpu_ram_wr,
   input wire logic [4:0] cpu_ram_addr,
   output logic [7:0] cpu_ram_rdata,
   output logic [4:0] transfer_byte_counter,
   output logic transfer_in_progress_flag,
   output logic transfer_complete_irq,
   output logic serial_clock_pin,
   output logic serial_data_out_pin,
   input wire logic serial_data_in_pin
);
   // ****************************************
   // declarations
   // ****************************************
   tws_state_t state_r;
   logic [7:0] sh_r;
   logic [3:0] bit_cnt_r;
   logic auto_r;
   logic stop_req_r;
   logic [4:0] cnt_r;
   logic [`TWS_GAP_W+1:0] gap_r;
   logic si_s1_r, si_s2_r, smp_r;
   logic fall_p, rise_p, sck;
   logic run;
   logic [7:0] ram_rdata;
   tws_ram_req_t eng_wr;
   logic byte_done;
   logic [4:0] eng_rd_addr;
   logic en;
   logic do_single;
   logic do_auto;
   logic [7:0] wr_ord;
   initial
   begin
      if (DEPTH != 32) $error("buffer depth must be 32");
   end
   assign en = serial_mode_control.port_enable_bit;
   // reverse bit order on the bus side only
   function automatic logic [7:0] rev8(input logic [7:0] d);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++)
         r[i] = d[7-i];
      return r;
   endfunction
   assign wr_ord = serial_mode_control.bit_order_select ? rev8(shift_wdata) : shift_wdata;
   // bus view of the shift register, bit order applied on the way out
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         shift_rdata <= '0;
      else
         shift_rdata <= serial_mode_control.bit_order_select ? rev8(sh_r) : sh_r;
   end
   // ****************************************
   // submodules
   // ****************************************
   assign run = (state_r == ST_SHIFT);
   tws_clk_gen #(.DW(DIV_W)) u_clk (
      .clk(clk),
      .rstn(rstn),
      .run(run),
      .div_sel(clock_divisor_select),
      .fall_p(fall_p),
      .rise_p(rise_p),
      .sck_r(sck)
   );
   tws_buf_ram #(.DEPTH(DEPTH), .AW(5)) u_ram (
      .clk(clk),
      .wr_a(cpu_ram_wr),
      .wr_b(eng_wr),
      .rd_addr_a(cpu_ram_addr),
      .rd_data_a(cpu_ram_rdata),
      .rd_addr_b(eng_rd_addr),
      .rd_data_b(ram_rdata)
   );
   // ****************************************
   // input synchroniser
   // ****************************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         si_s1_r <= 1'b0;
         si_s2_r <= 1'b0;
      end
      else
      begin
         si_s1_r <= serial_data_in_pin;
         si_s2_r <= si_s1_r;
      end
   end
   // ****************************************
   // sequencer
   // ****************************************
   assign byte_done = rise_p && (bit_cnt_r == 4'd7);
   // idle reads entry 0 so the first load after a start sees the first byte
   assign eng_rd_addr = (state_r == ST_IDLE) ? 5'd0 : cnt_r;
   assign do_single = shift_wr && en && !serial_mode_control.auto_transfer_enable
      && (state_r == ST_IDLE);
   assign do_auto = auto_start_trigger && en && serial_mode_control.auto_transfer_enable
      && (state_r == ST_IDLE);
   assign eng_wr.en = byte_done && auto_r && serial_mode_control.receive_enable_bit;
   assign eng_wr.addr = cnt_r;
   assign eng_wr.data = {sh_r[6:0], smp_r};
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= ST_IDLE;
         auto_r <= 1'b0;
         cnt_r <= '0;
         gap_r <= '0;
         transfer_complete_irq <= 1'b0;
      end
      else if (!en)
      begin
         // disable aborts silently, counter kept for progress
         state_r <= ST_IDLE;
         auto_r <= 1'b0;
         transfer_complete_irq <= 1'b0;
      end
      else
      begin
         transfer_complete_irq <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               if (do_auto)
               begin
                  auto_r <= 1'b1;
                  cnt_r <= '0;
                  state_r <= ST_LOAD;
               end
               else if (do_single)
               begin
                  auto_r <= 1'b0;
                  state_r <= ST_SHIFT;
               end
            end
            ST_LOAD:
               state_r <= ST_SHIFT;
            ST_SHIFT:
            begin
               if (byte_done)
               begin
                  if (!auto_r)
                  begin
                     state_r <= ST_IDLE;
                     transfer_complete_irq <= 1'b1;
                  end
                  else if (stop_req_r || (cnt_r == transfer_end_point
                           && !serial_mode_control.continuous_transfer_bit))
                  begin
                     state_r <= ST_IDLE;
                     auto_r <= 1'b0;
                     transfer_complete_irq <= 1'b1;
                     if (!stop_req_r)
                        cnt_r <= cnt_r + 5'd1;
                  end
                  else
                  begin
                     cnt_r <= (cnt_r == transfer_end_point) ? 5'd0 : cnt_r + 5'd1;
                     gap_r <= {transfer_interval_setting, 2'b00};
                     state_r <= ST_GAP;
                  end
               end
            end
            ST_GAP:
            begin
               if (gap_r == '0)
                  state_r <= ST_LOAD;
               else
                  gap_r <= gap_r - 1'b1;
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end
   // stop request held until the current byte ends
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         stop_req_r <= 1'b0;
      else if (!auto_r || state_r == ST_IDLE)
         stop_req_r <= 1'b0;
      else if (auto_stop_trigger)
         stop_req_r <= 1'b1;
   end
   // ****************************************
   // shift path
   // ****************************************
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sh_r <= '0;
         bit_cnt_r <= '0;
         smp_r <= 1'b0;
         serial_data_out_pin <= 1'b1;
      end
      else
      begin
         if (do_single)
         begin
            sh_r <= wr_ord;
            bit_cnt_r <= '0;
         end
         else if (state_r == ST_LOAD)
         begin
            sh_r <= serial_mode_control.transmit_enable_bit ? ram_rdata : 8'hff;
            bit_cnt_r <= '0;
         end
         else if (fall_p)
         begin
            serial_data_out_pin <= sh_r[7];
            smp_r <= si_s2_r;
         end
         else if (rise_p)
         begin
            sh_r <= {sh_r[6:0], smp_r};
            bit_cnt_r <= bit_cnt_r + 4'd1;
         end
      end
   end
   assign serial_clock_pin = sck;
   assign transfer_in_progress_flag = (state_r != ST_IDLE);
   assign transfer_byte_counter = cnt_r;
   // ****************************************
   // checks
   // ****************************************
   single_stop_a: assert property (@(posedge clk) disable iff (!rstn)
      (byte_done && !auto_r && en) |=> (transfer_complete_irq && !transfer_in_progress_flag))
      else $error("single byte did not finish");
   no_start_dis_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_r == ST_IDLE && !en) |=> (state_r == ST_IDLE))
      else $error("started while disabled");
   idle_high_a: assert property (@(posedge clk) disable iff (!rstn)
      (state_r != ST_SHIFT) |=> serial_clock_pin)
      else $error("serial clock not idle high");
   dis_no_irq_a: assert property (@(posedge clk) disable iff (!rstn)
      !en |=> !transfer_complete_irq)
      else $error("complete raised on disable");
   eight_bits_a: assert property (@(posedge clk) disable iff (!rstn)
      run |-> (bit_cnt_r < 4'd8))
      else $error("frame exceeded eight bits");
   cont_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
      (byte_done && auto_r && en && !stop_req_r && serial_mode_control.continuous_transfer_bit
       && cnt_r == transfer_end_point) |=> (cnt_r == 5'd0))
      else $error("counter did not wrap");
   auto_wr_a: assert property (@(posedge clk) disable iff (!rstn)
      (byte_done && auto_r && serial_mode_control.receive_enable_bit) |-> eng_wr.en)
      else $error("received byte not stored");
   stop_end_a: assert property (@(posedge clk) disable iff (!rstn)
      (byte_done && auto_r && stop_req_r && en) |=> (state_r == ST_IDLE && transfer_complete_irq))
      else $error("stop trigger not honoured");
endmodule
`default_nettype wire

// *** testbench/tws_partner_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// far-side serial peripheral
// ****
module tws_partner_model (
   input wire logic rstn,
   input wire logic sck,
   input wire logic dout,
   input wire logic [7:0] reply,
   output logic din,
   output logic [7:0] got,
   output int nbytes
);
   int nbit;
   logic [7:0] sh;
   initial
   begin
      nbit = 0;
      nbytes = 0;
      got = 8'h00;
      sh = 8'h00;
      din = 1'b1;
   end
   // first reply bit waits on the line between frames
   always @(reply)
   begin
      if (nbit == 0)
      begin
         din = reply[7];
      end
   end
   // capture on rise, present next reply bit after it
   always @(posedge sck)
   begin
      if (rstn === 1'b1)
      begin
         sh = {sh[6:0], dout};
         nbit = (nbit + 1) % 8;
         if (nbit == 0)
         begin
            got = sh;
            nbytes = nbytes + 1;
         end
         din <= reply[7 - nbit];
      end
   end
endmodule
`default_nettype wire

// *** testbench/tws_serial_port_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// serial port bench
// ****
module tws_serial_port_tb
   import tws_pkg::*;
();
   logic clk;
   logic rstn;
   tws_mode_t mode;
   tws_ram_req_t ram_wr;
   logic [3:0] div;
   logic [4:0] endp, cnt, ram_addr;
   logic [7:0] gap, swd, srd, ram_rd, reply, got;
   logic ast, asp, swr, flag, irq, sck, dout, din;
   int nbytes, irq_n, cyc, n0, i0, k;
   int mismatches, samples_checked;

   tws_serial_port dut_u (.clk(clk), .rstn(rstn), .serial_mode_control(mode), .clock_divisor_select(div),
      .transfer_end_point(endp), .transfer_interval_setting(gap), .auto_start_trigger(ast),
      .auto_stop_trigger(asp), .shift_wr(swr), .shift_wdata(swd), .shift_rdata(srd), .cpu_ram_wr(ram_wr),
      .cpu_ram_addr(ram_addr), .cpu_ram_rdata(ram_rd), .transfer_byte_counter(cnt),
      .transfer_in_progress_flag(flag), .transfer_complete_irq(irq), .serial_clock_pin(sck),
      .serial_data_out_pin(dout), .serial_data_in_pin(din));
   tws_partner_model far_u (.rstn(rstn), .sck(sck), .dout(dout), .reply(reply), .din(din), .got(got),
      .nbytes(nbytes));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (irq === 1'b1)
      begin
         irq_n <= irq_n + 1;
      end
      if (cyc == 20000)
      begin
         mismatches = mismatches + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic wr_shift(input logic [7:0] d);
      @(negedge clk);
      swd = d;
      swr = 1'b1;
      @(negedge clk);
      swr = 1'b0;
   endtask

   task automatic trig(input logic stop);
      @(negedge clk);
      if (stop)
         asp = 1'b1;
      else
         ast = 1'b1;
      @(negedge clk);
      asp = 1'b0;
      ast = 1'b0;
   endtask

   task automatic wait_idle();
      k = 0;
      @(negedge clk);
      while (flag !== 1'b0 && k < 4000)
      begin
         @(negedge clk);
         k++;
      end
      chk({7'h00, flag}, 8'h00);
      repeat (2) @(negedge clk);
   endtask

   task automatic ram_put(input logic [4:0] a, input logic [7:0] d);
      @(negedge clk);
      ram_wr = '{1'b1, a, d};
      @(negedge clk);
      ram_wr.en = 1'b0;
   endtask

   task automatic ram_chk(input logic [4:0] a, input logic [7:0] e);
      @(negedge clk);
      ram_addr = a;
      @(negedge clk);
      chk(ram_rd, e);
   endtask

   task automatic mark();
      n0 = nbytes;
      i0 = irq_n;
   endtask

   initial
   begin
      rstn = 1'b0;
      mode = tws_mode_t'(6'h00);
      ram_wr = '0;
      div = 4'h5;
      endp = 5'h00;
      ram_addr = 5'h00;
      gap = 8'h01;
      swd = 8'h00;
      reply = 8'hff;
      {ast, asp, swr} = 3'h0;
      {mismatches, samples_checked, irq_n, cyc} = '0;
      repeat (5) @(negedge clk);
      chk({4'h0, sck, dout, flag, irq}, 8'h0c);
      chk({3'h0, cnt}, 8'h00);
      rstn = 1'b1;
      // single byte, msb first, continuous bit set
      mode = tws_mode_t'(6'h2e);
      reply = 8'h3c;
      mark();
      wr_shift(8'ha5);
      wait_idle();
      chk(got, 8'ha5);
      chk(srd, 8'h3c);
      chk(8'(irq_n - i0), 8'h01);
      // lsb first reverses both ways
      mode = tws_mode_t'(6'h27);
      reply = 8'h80;
      wr_shift(8'h12);
      wait_idle();
      chk(got, 8'h48);
      chk(srd, 8'h01);
      // write while disabled, then enable
      mode = tws_mode_t'(6'h0e);
      mark();
      wr_shift(8'h77);
      mode = tws_mode_t'(6'h2e);
      repeat (40) @(negedge clk);
      chk({7'h00, flag}, 8'h00);
      chk(8'(nbytes - n0), 8'h00);
      // write while busy is dropped
      wr_shift(8'h11);
      wr_shift(8'h22);
      wait_idle();
      chk(got, 8'h11);
      chk(8'(irq_n - i0), 8'h01);
      // automatic three bytes
      for (int i = 0; i < 3; i++)
         ram_put(5'(i), 8'(8'h10 * (i + 1)));
      endp = 5'h02;
      reply = 8'h5a;
      mode = tws_mode_t'(6'h36);
      mark();
      trig(1'b0);
      wait_idle();
      chk(got, 8'h30);
      chk(8'(nbytes - n0), 8'h03);
      chk({3'h0, cnt}, 8'h03);
      chk(8'(irq_n - i0), 8'h01);
      for (int i = 0; i < 3; i++)
         ram_chk(5'(i), 8'h5a);
      // continuous run, then stop trigger
      mode = tws_mode_t'(6'h3e);
      endp = 5'h01;
      mark();
      trig(1'b0);
      k = 0;
      while (nbytes == n0 && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
      chk(got, 8'h5a);
      while (nbytes - n0 < 3 && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
      chk({7'h00, flag}, 8'h01);
      chk(8'(irq_n - i0), 8'h00);
      trig(1'b1);
      wait_idle();
      chk(8'(irq_n - i0), 8'h01);
      // stop during first byte
      mode = tws_mode_t'(6'h36);
      endp = 5'h04;
      mark();
      trig(1'b0);
      trig(1'b1);
      wait_idle();
      chk({3'h0, cnt}, 8'h00);
      chk(8'(nbytes - n0), 8'h01);
      chk(8'(irq_n - i0), 8'h01);
      // automatic byte with both directions disabled
      mode = tws_mode_t'(6'h30);
      endp = 5'h00;
      reply = 8'hc3;
      mark();
      trig(1'b0);
      wait_idle();
      chk(got, 8'hff);
      chk({3'h0, cnt}, 8'h01);
      chk(8'(irq_n - i0), 8'h01);
      ram_chk(5'h00, 8'h5a);
      // abort by clearing the enable
      mark();
      trig(1'b0);
      repeat (30) @(negedge clk);
      mode = tws_mode_t'(6'h16);
      repeat (3) @(negedge clk);
      chk({7'h00, flag}, 8'h00);
      repeat (200) @(negedge clk);
      chk(8'(irq_n - i0), 8'h00);
      chk({3'h0, cnt}, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
